// File: src/rfac_rx_accept.sv
// rx frame acceptance, copy control, byte fifo and apb register slave
`default_nettype none
`include "rfac_defines.svh"

module rfac_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = count_reg != (AW+1)'(DEPTH);
    assign out_valid = count_reg != '0;
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];
    assign count = count_reg;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // depth is a power of two, so pointers wrap by themselves
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end
endmodule : rfac_fifo

module rfac_rx_accept (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive byte stream
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_sof,
    input wire logic rx_eof,
    input wire logic rx_fcs,
    // frame class, valid with rx_sof
    input wire logic rx_addr_hit,
    input wire rfac_pkg::rfac_chan_type rx_addr_ch,
    input wire logic rx_bcast,
    input wire logic rx_mcast_hit,
    input wire logic rx_ctrl,
    input wire logic rx_pause,
    // frame status, valid with rx_eof
    input wire logic rx_crc_err,
    input wire logic rx_align_err,
    input wire logic rx_code_err,
    // dma byte stream
    output logic dma_valid,
    input wire logic dma_ready,
    output logic [7:0] dma_data,
    // end-of-packet descriptor
    output logic desc_valid,
    output logic desc_drop,
    output rfac_pkg::rfac_chan_type desc_ch,
    output rfac_pkg::rfac_len_type desc_len,
    output logic desc_ctrl_flag,
    output logic desc_runt,
    output logic desc_short_ok,
    output logic desc_err,
    output logic desc_no_addr_hit,
    output logic desc_qos,
    // flow control
    output logic pause_act
);
    import rfac_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [31:0] cfg_reg;
    logic [31:0] cfg_f_reg;
    logic pause_en_reg;
    rfac_len_type buf_len_reg;
    rfac_len_type buf_len_f_reg;
    rfac_len_type acc_cnt_reg;
    rfac_len_type drop_cnt_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic apb_access;
    logic apb_write;
    logic [31:0] rd_data;
    logic rd_hit;

    assign apb_access = psel && penable && !pready_reg;
    assign apb_write = ce && psel && penable && pready_reg && pwrite && !pslverr_reg;

    always_comb begin
        rd_hit = 1'b1;
        unique case (paddr)
            `RFAC_CFG_OFS: rd_data = cfg_reg;
            `RFAC_MACCTL_OFS: rd_data = {31'h0000_0000, pause_en_reg};
            `RFAC_BUFLEN_OFS: rd_data = {16'h0000, buf_len_reg};
            `RFAC_STAT_OFS: rd_data = {drop_cnt_reg, acc_cnt_reg};
            default: begin
                rd_data = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // one wait state: answer comes one edge after access starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            pready_reg <= apb_access;
            if (apb_access) begin
                pslverr_reg <= !rd_hit;
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
            end
        end
    end

    // reserved bits never store, so they read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= `RFAC_CFG_RST;
            pause_en_reg <= 1'b0;
            buf_len_reg <= `RFAC_BUFLEN_RST;
        end else if (apb_write) begin
            if (paddr == `RFAC_CFG_OFS) begin
                cfg_reg <= pwdata & `RFAC_CFG_WMASK;
            end
            if (paddr == `RFAC_MACCTL_OFS) begin
                pause_en_reg <= pwdata[`RFAC_PAUSE_EN_BIT];
            end
            if (paddr == `RFAC_BUFLEN_OFS) begin
                buf_len_reg <= pwdata[15:0];
            end
        end
    end

    // ----------------------------------------
    // frame classification at start of frame
    // ----------------------------------------
    rfac_state_type state_reg;
    logic cls_keep;
    logic cls_nohit;
    rfac_chan_type cls_ch;
    logic frm_keep_reg;
    logic frm_nohit_reg;
    logic frm_ctrl_reg;
    logic frm_pause_reg;
    logic pause_en_f_reg;
    rfac_chan_type frm_ch_reg;
    rfac_len_type len_cnt_reg;
    rfac_len_type all_cnt_reg;

    always_comb begin
        cls_keep = 1'b1;
        cls_nohit = 1'b0;
        cls_ch = rx_addr_ch;
        if (rx_addr_hit) begin
            cls_ch = rx_addr_ch;
        end else if (rx_bcast && cfg_reg[`RFAC_BCAST_EN_BIT]) begin
            cls_ch = cfg_reg[`RFAC_BCAST_LSB +: 3];
        end else if (rx_mcast_hit && cfg_reg[`RFAC_MCAST_EN_BIT]) begin
            cls_ch = cfg_reg[`RFAC_MCAST_LSB +: 3];
        end else if (cfg_reg[`RFAC_UNMATCHED_BIT]) begin
            cls_ch = cfg_reg[`RFAC_CATCH_LSB +: 3];
            cls_nohit = 1'b1;
        end else begin
            cls_keep = 1'b0;
        end
        if (rx_ctrl && !cfg_reg[`RFAC_CTRL_BIT]) begin
            cls_keep = 1'b0;
        end
    end

    // ----------------------------------------
    // per-byte path
    // ----------------------------------------
    logic take;
    logic in_frame;
    logic [31:0] cur_cfg;
    rfac_len_type cur_buf;
    rfac_len_type cur_len;
    rfac_len_type cur_all;
    logic cur_keep;
    logic counted;
    logic room;
    logic push;
    rfac_len_type len_next;
    rfac_len_type all_next;
    logic frm_err;
    logic frm_short;
    logic frm_drop;
    logic cur_ctrl;
    logic cur_pause;
    logic cur_pause_en;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic [$clog2(`RFAC_FIFO_DEPTH):0] fifo_count;
    logic rx_ready_reg;

    // bytes outside a frame are consumed and thrown away
    assign take = ce && rx_valid && rx_ready_reg;
    assign in_frame = rx_sof || (state_reg == RFAC_FRAME);
    assign cur_cfg = rx_sof ? cfg_reg : cfg_f_reg;
    assign cur_buf = rx_sof ? buf_len_reg : buf_len_f_reg;
    assign cur_len = rx_sof ? 16'h0000 : len_cnt_reg;
    assign cur_all = rx_sof ? 16'h0000 : all_cnt_reg;
    assign cur_keep = rx_sof ? cls_keep : frm_keep_reg;
    assign cur_ctrl = rx_sof ? rx_ctrl : frm_ctrl_reg;
    assign cur_pause = rx_sof ? rx_pause : frm_pause_reg;
    assign cur_pause_en = rx_sof ? pause_en_reg : pause_en_f_reg;
    assign counted = !rx_fcs || cur_cfg[`RFAC_KEEP_FCS_BIT];
    assign room = !cur_cfg[`RFAC_SINGLE_BIT] || (cur_len < cur_buf);
    assign push = take && in_frame && cur_keep && counted && room && fifo_in_ready;
    assign len_next = (counted && cur_len != `RFAC_LEN_MAX) ? cur_len + 16'h0001 : cur_len;
    assign all_next = (cur_all != `RFAC_LEN_MAX) ? cur_all + 16'h0001 : cur_all;
    assign frm_err = rx_crc_err || rx_align_err || rx_code_err;
    assign frm_short = all_next < `RFAC_SHORT_LEN;
    assign frm_drop = !cur_keep
        || (frm_short && !cur_cfg[`RFAC_SHORT_BIT])
        || (!frm_short && frm_err && !cur_cfg[`RFAC_ERR_BIT]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RFAC_IDLE;
        end else if (take && in_frame) begin
            state_reg <= rx_eof ? RFAC_IDLE : RFAC_FRAME;
        end
    end

    // settings held for the whole frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_f_reg <= `RFAC_CFG_RST;
            buf_len_f_reg <= `RFAC_BUFLEN_RST;
            pause_en_f_reg <= 1'b0;
            frm_keep_reg <= 1'b0;
            frm_nohit_reg <= 1'b0;
            frm_ctrl_reg <= 1'b0;
            frm_pause_reg <= 1'b0;
            frm_ch_reg <= 3'h0;
        end else if (take && rx_sof) begin
            cfg_f_reg <= cfg_reg;
            buf_len_f_reg <= buf_len_reg;
            pause_en_f_reg <= pause_en_reg;
            frm_keep_reg <= cls_keep;
            frm_nohit_reg <= cls_nohit;
            frm_ctrl_reg <= rx_ctrl;
            frm_pause_reg <= rx_pause;
            frm_ch_reg <= cls_ch;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_cnt_reg <= 16'h0000;
            all_cnt_reg <= 16'h0000;
        end else if (take && in_frame) begin
            len_cnt_reg <= len_next;
            all_cnt_reg <= all_next;
        end
    end

    // ----------------------------------------
    // end-of-packet descriptor
    // ----------------------------------------
    logic desc_valid_reg;
    logic desc_drop_reg;
    rfac_chan_type desc_ch_reg;
    rfac_len_type desc_len_reg;
    logic desc_ctrl_reg;
    logic desc_runt_reg;
    logic desc_short_ok_reg;
    logic desc_err_reg;
    logic desc_nohit_reg;
    logic desc_qos_reg;
    logic pause_act_reg;
    logic eop;

    assign eop = take && in_frame && rx_eof;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desc_valid_reg <= 1'b0;
            desc_drop_reg <= 1'b0;
            desc_ch_reg <= 3'h0;
            desc_len_reg <= 16'h0000;
            desc_ctrl_reg <= 1'b0;
            desc_runt_reg <= 1'b0;
            desc_short_ok_reg <= 1'b0;
            desc_err_reg <= 1'b0;
            desc_nohit_reg <= 1'b0;
            desc_qos_reg <= 1'b0;
        end else if (ce) begin
            desc_valid_reg <= eop;
            if (eop) begin
                desc_drop_reg <= frm_drop;
                desc_ch_reg <= rx_sof ? cls_ch : frm_ch_reg;
                desc_len_reg <= len_next;
                desc_ctrl_reg <= cur_ctrl;
                desc_runt_reg <= frm_short && frm_err;
                desc_short_ok_reg <= frm_short && !frm_err;
                desc_err_reg <= !frm_short && frm_err;
                desc_nohit_reg <= rx_sof ? cls_nohit : frm_nohit_reg;
                desc_qos_reg <= cur_cfg[`RFAC_QOS_BIT];
            end
        end
    end

    // pause acts even when the control frame itself is filtered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_act_reg <= 1'b0;
        end else if (ce) begin
            pause_act_reg <= eop && cur_pause && cur_pause_en && !frm_err;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_cnt_reg <= 16'h0000;
            drop_cnt_reg <= 16'h0000;
        end else if (eop) begin
            if (frm_drop) begin
                drop_cnt_reg <= drop_cnt_reg + 16'h0001;
            end else begin
                acc_cnt_reg <= acc_cnt_reg + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // byte fifo and dma output stage
    // ----------------------------------------
    logic dma_valid_reg;
    logic [7:0] dma_data_reg;

    rfac_fifo #(
        .WIDTH(`RFAC_FIFO_WIDTH),
        .DEPTH(`RFAC_FIFO_DEPTH)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .ce(ce),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(rx_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    // ready lags one edge, so keep one slot spare for the byte in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_ready_reg <= 1'b0;
        end else if (ce) begin
            rx_ready_reg <= fifo_count < ($clog2(`RFAC_FIFO_DEPTH) + 1)'(`RFAC_FIFO_DEPTH - 1);
        end
    end

    assign fifo_out_ready = !dma_valid_reg || dma_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_valid_reg <= 1'b0;
            dma_data_reg <= 8'h00;
        end else if (ce && fifo_out_ready) begin
            dma_valid_reg <= fifo_out_valid;
            dma_data_reg <= fifo_out_data;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign rx_ready = rx_ready_reg;
    assign dma_valid = dma_valid_reg;
    assign dma_data = dma_data_reg;
    assign desc_valid = desc_valid_reg;
    assign desc_drop = desc_drop_reg;
    assign desc_ch = desc_ch_reg;
    assign desc_len = desc_len_reg;
    assign desc_ctrl_flag = desc_ctrl_reg;
    assign desc_runt = desc_runt_reg;
    assign desc_short_ok = desc_short_ok_reg;
    assign desc_err = desc_err_reg;
    assign desc_no_addr_hit = desc_nohit_reg;
    assign desc_qos = desc_qos_reg;
    assign pause_act = pause_act_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_fcs_not_stored: assert property (push && rx_fcs |-> cfg_f_reg[`RFAC_KEEP_FCS_BIT] || rx_sof)
        else $error("fcs byte stored while fcs drop selected");
    a_single_buf_cut: assert property (push && !rx_sof && cfg_f_reg[`RFAC_SINGLE_BIT]
        |-> len_cnt_reg < buf_len_f_reg)
        else $error("byte stored past first buffer");
    a_len_counts_all: assert property (eop && cur_cfg[`RFAC_KEEP_FCS_BIT] |=> desc_len_reg == $past(all_next))
        else $error("descriptor length not full frame count");
    a_qos_follows_cfg: assert property (eop && !rx_sof |=> desc_qos_reg == $past(cfg_f_reg[`RFAC_QOS_BIT]))
        else $error("qos flag differs from frame setting");
    a_ctrl_filtered: assert property (eop && cur_ctrl && !cur_cfg[`RFAC_CTRL_BIT] |=> desc_drop_reg)
        else $error("control frame copied while filtering");
    a_ctrl_flagged: assert property (desc_valid_reg && !desc_drop_reg && desc_ctrl_reg
        |-> $past(cur_cfg[`RFAC_CTRL_BIT]))
        else $error("copied control frame without copy enable");
    a_pause_acted: assert property (eop && cur_pause && cur_pause_en && !frm_err |=> pause_act_reg)
        else $error("pause frame not acted on");
    a_short_filter: assert property (desc_valid_reg && !desc_drop_reg && (desc_runt_reg || desc_short_ok_reg)
        |-> $past(cur_cfg[`RFAC_SHORT_BIT]))
        else $error("short frame copied while filtering");
    a_runt_is_short: assert property (desc_valid_reg && desc_runt_reg |-> desc_len_reg < `RFAC_SHORT_LEN)
        else $error("runt flag on long frame");
    a_err_filter: assert property (eop && !frm_short && frm_err && !cur_cfg[`RFAC_ERR_BIT] |=> desc_drop_reg)
        else $error("error frame copied while filtering");
    a_nohit_catchall: assert property (eop && !rx_sof && frm_nohit_reg
        |=> desc_no_addr_hit && desc_ch_reg == $past(cfg_f_reg[`RFAC_CATCH_LSB +: 3]))
        else $error("unmatched frame not on catchall channel");
    a_cfg_frozen: assert property (ce && state_reg == RFAC_FRAME && !(take && rx_sof) |=> $stable(cfg_f_reg))
        else $error("frame settings changed mid frame");
endmodule : rfac_rx_accept

`default_nettype wire

// File: src/rfac_defines.svh
// register map, field positions, reset values and limits for rx frame acceptance
`ifndef RFAC_DEFINES_SVH
`define RFAC_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RFAC_CFG_OFS 12'h000
`define RFAC_MACCTL_OFS 12'h004
`define RFAC_BUFLEN_OFS 12'h008
`define RFAC_STAT_OFS 12'h00C

// ----------------------------------------
// rx_frame_accept_config fields
// ----------------------------------------
`define RFAC_CFG_RST 32'h0000_0000
`define RFAC_CFG_WMASK 32'h71E7_2727
`define RFAC_KEEP_FCS_BIT 30
`define RFAC_QOS_BIT 29
`define RFAC_SINGLE_BIT 28
`define RFAC_CTRL_BIT 24
`define RFAC_SHORT_BIT 23
`define RFAC_ERR_BIT 22
`define RFAC_UNMATCHED_BIT 21
`define RFAC_CATCH_LSB 16
`define RFAC_BCAST_EN_BIT 13
`define RFAC_BCAST_LSB 8
`define RFAC_MCAST_EN_BIT 5
`define RFAC_MCAST_LSB 0

// ----------------------------------------
// other registers and limits
// ----------------------------------------
`define RFAC_MACCTL_RST 32'h0000_0000
`define RFAC_PAUSE_EN_BIT 0
`define RFAC_BUFLEN_RST 16'h0600
`define RFAC_SHORT_LEN 16'h0040
`define RFAC_LEN_MAX 16'hFFFF
`define RFAC_FIFO_WIDTH 8
`define RFAC_FIFO_DEPTH 4

`endif

// File: src/rfac_pkg.sv
// types shared by the rx frame acceptance block
`default_nettype none

package rfac_pkg;
    typedef logic [2:0] rfac_chan_type;
    typedef logic [15:0] rfac_len_type;
    typedef enum logic [1:0] {
        RFAC_IDLE = 2'b01,
        RFAC_FRAME = 2'b10
    } rfac_state_type;
endpackage : rfac_pkg

`default_nettype wire

// File: testbench/rfac_dma_sink.sv
// receive dma sink model with random back-pressure
`default_nettype none

module rfac_dma_sink (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // dma byte stream
    input wire logic dma_valid,
    output logic dma_ready,
    input wire logic [7:0] dma_data,
    // bytes taken so far
    output int count
);
    timeunit 1ns;
    timeprecision 1ps;

    // stalls often so the fifo fills and the rx side gets refused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_ready <= 1'b0;
            count <= 0;
        end else begin
            dma_ready <= ($urandom % 3) != 0;
            if (dma_valid && dma_ready) begin
                count <= count + 1;
            end
        end
    end
endmodule : rfac_dma_sink

`default_nettype wire

// File: testbench/rfac_rx_accept_tb.sv
// self-checking bench for rx frame acceptance against a dma sink model
`default_nettype none
`include "rfac_defines.svh"

module rfac_rx_accept_tb import rfac_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, pause_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cfg;
    logic rx_valid, rx_ready, rx_sof, rx_eof, rx_fcs, rx_addr_hit, rx_bcast, rx_mcast_hit, rx_ctrl, rx_pause;
    logic [7:0] rx_data, dma_data;
    rfac_chan_type rx_addr_ch, desc_ch;
    logic rx_crc_err, rx_align_err, rx_code_err, dma_valid, dma_ready, desc_valid, desc_drop;
    rfac_len_type desc_len;
    logic desc_ctrl_flag, desc_runt, desc_short_ok, desc_err, desc_no_addr_hit, desc_qos, pause_act;
    logic [15:0] buflen;
    int n_errors, checked, dma_count, frm_c0, n_acc, n_drop;

    rfac_rx_accept dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_valid, .rx_ready, .rx_data, .rx_sof, .rx_eof, .rx_fcs, .rx_addr_hit,
        .rx_addr_ch, .rx_bcast, .rx_mcast_hit, .rx_ctrl, .rx_pause, .rx_crc_err, .rx_align_err, .rx_code_err,
        .dma_valid, .dma_ready, .dma_data, .desc_valid, .desc_drop, .desc_ch, .desc_len, .desc_ctrl_flag,
        .desc_runt, .desc_short_ok, .desc_err, .desc_no_addr_hit, .desc_qos, .pause_act);

    rfac_dma_sink sink (.pclk, .presetn, .dma_valid, .dma_ready, .dma_data, .count(dma_count));

    // kept bytes leave in order, fcs last, so byte k of a frame carries value k
    always @(posedge pclk) begin
        if (presetn && dma_valid && dma_ready) begin
            chk(dma_data, 8'(dma_count - frm_c0), "dma byte order");
        end
    end

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // ----------------------------------------
    // tasks and expectations
    // ----------------------------------------
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : chk

    // sel 0 waits on pready, sel 1 on rx_ready; read right after the edge, so it is what the design sampled
    task automatic wait_high(input int sel);
        int k;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while ((sel ? rx_ready : pready) !== 1'b1 && k < 500);
        if (k >= 500) begin
            n_errors++;
            finish_test();
        end
    endtask : wait_high

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        wait_high(0);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // extra edge keeps psel from being assigned twice in one step
        @(posedge pclk);
    endtask : apb

    // {drop, ch, len, ctrl, runt, short_ok, err, no_hit, qos}
    function automatic logic [25:0] expect_desc(int n, logic [4:0] cls, logic e, rfac_chan_type ach);
        logic sh, drop, nohit;
        rfac_chan_type ch;
        rfac_len_type len;
        sh = n < 64;
        nohit = 1'b0;
        drop = 1'b0;
        ch = ach;
        if (cls[4]) ch = ach;
        else if (cls[3] && cfg[13]) ch = cfg[10:8];
        else if (cls[2] && cfg[5]) ch = cfg[2:0];
        else if (cfg[21]) begin
            ch = cfg[18:16];
            nohit = 1'b1;
        end else drop = 1'b1;
        if (cls[1] && !cfg[24]) drop = 1'b1;
        if (sh ? !cfg[23] : (e && !cfg[22])) drop = 1'b1;
        len = cfg[30] ? 16'(n) : 16'(n - 4);
        return {drop, ch, len, cls[1], sh & e, sh & ~e, ~sh & e, nohit, cfg[29]};
    endfunction : expect_desc

    task automatic run_frame(input int n, input logic [4:0] cls, input logic [2:0] errs, input rfac_chan_type ach);
        logic [25:0] exp;
        int c0, k, idle, want;
        cls[1] = cls[1] | cls[0];
        exp = expect_desc(n, cls, |errs, ach);
        c0 = dma_count;
        frm_c0 = c0;
        n_drop += exp[25];
        n_acc += !exp[25];
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_data <= 8'(i);
            {rx_sof, rx_eof, rx_fcs} <= {i == 0, i == n - 1, i >= n - 4};
            {rx_addr_hit, rx_bcast, rx_mcast_hit, rx_ctrl, rx_pause} <= cls;
            {rx_crc_err, rx_align_err, rx_code_err} <= errs;
            rx_addr_ch <= ach;
            wait_high(1);
        end
        {rx_valid, rx_sof, rx_eof, rx_fcs} <= '0;
        @(negedge pclk);
        chk(desc_valid, 1'b1, "desc pulse");
        if (exp[25]) chk(desc_drop, 1'b1, "dropped");
        else chk({desc_drop, desc_ch, desc_len, desc_ctrl_flag, desc_runt, desc_short_ok, desc_err,
            desc_no_addr_hit, desc_qos}, exp, "descriptor");
        chk(pause_act, pause_en & cls[0] & ~|errs, "pause");
        k = 0;
        idle = 0;
        while (idle < 8 && k < 2000) begin
            @(negedge pclk);
            idle = dma_valid ? 0 : idle + 1;
            k++;
        end
        if (k >= 2000) begin
            n_errors++;
            finish_test();
        end
        want = (cfg[28] && buflen < exp[21:6]) ? int'(buflen) : int'(exp[21:6]);
        if (!exp[25]) chk(dma_count - c0, want, "bytes to dma");
        @(posedge pclk);
    endtask : run_frame

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, rx_valid, rx_sof, rx_eof, rx_fcs} = '0;
        {rx_addr_hit, rx_bcast, rx_mcast_hit, rx_ctrl, rx_pause, rx_crc_err, rx_align_err, rx_code_err} = '0;
        paddr = '0;
        pwdata = '0;
        rx_data = '0;
        rx_addr_ch = '0;
        n_errors = 0;
        checked = 0;
        frm_c0 = 0;
        n_acc = 0;
        n_drop = 0;
        void'($urandom(63916));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `RFAC_CFG_OFS, '0);
        chk(rd, `RFAC_CFG_RST, "cfg reset");
        apb(1'b0, `RFAC_MACCTL_OFS, '0);
        chk(rd, `RFAC_MACCTL_RST, "mac ctrl reset");
        apb(1'b0, `RFAC_BUFLEN_OFS, '0);
        chk(rd, {16'h0000, `RFAC_BUFLEN_RST}, "buffer length reset");
        apb(1'b1, `RFAC_CFG_OFS, 32'hFFFF_FFFF);
        apb(1'b0, `RFAC_CFG_OFS, '0);
        chk(rd, `RFAC_CFG_WMASK, "cfg read-only bits");
        apb(1'b0, 12'h010, '0);
        chk({er, rd}, 33'h1_0000_0000, "unmapped");
        // half the frames sit on the 64 byte boundary
        for (int f = 0; f < 60; f++) begin
            cfg = $urandom & `RFAC_CFG_WMASK;
            buflen = 16'(8 + $urandom % 64);
            pause_en = 1'($urandom);
            apb(1'b1, `RFAC_CFG_OFS, cfg);
            apb(1'b1, `RFAC_BUFLEN_OFS, {16'h0000, buflen});
            apb(1'b1, `RFAC_MACCTL_OFS, {31'h0, pause_en});
            run_frame(($urandom % 2) ? 62 + $urandom % 4 : 5 + $urandom % 90, 5'($urandom),
                ($urandom % 4 == 0) ? 3'(1 << ($urandom % 3)) : 3'h0, 3'($urandom));
        end
        apb(1'b0, `RFAC_STAT_OFS, '0);
        chk(rd, {16'(n_drop), 16'(n_acc)}, "frame counters");
        finish_test();
    end
endmodule : rfac_rx_accept_tb

`default_nettype wire
